// >>> core/sca_defines.svh
// Purpose: Constants for the switch configuration and ADC register slice
// Assumes: 40 MHz core clock, 6-bit register index, 16-bit registers
// Notes:   Summary of operation is listed below
//
// Summary of operation
// - Stagger bit 0 delays the second channel's first PWM edge 100 us.
// - The merge bit takes a write only with all channels off and none set.
// - The merge bit drives the channels-in-parallel indication.
// - An enabled watchdog times out when no valid frame arrives in time.
// - Watchdog select codes 0..3 give 400 us, 400 ms, 800 ms, 1200 ms.
// - Output voltage sensing is skipped while its disable bit is 1.
// - Temperature sensing is skipped while its disable bit is 1.
// - Load current sensing is skipped while its disable bit is 1.
// - Supply voltage sensing is skipped while its disable bit is 1.
// - The fresh flag is 1 when a new supply sample is unread.
// - The supply result is 10 unsigned bits, upper bits zero but fresh.
// - No conversion runs while the converter enable is 0.
// - A masked watchdog error reaches neither fault register nor pin.
`ifndef SCA_DEFINES_SVH
`define SCA_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SCA_OFS_FAULT   6'h02
`define SCA_OFS_DEVCFG  6'h09
`define SCA_OFS_ADCCFG  6'h0A
`define SCA_OFS_VBBRES  6'h0B

// ---------------------------------------------------------------
// Field positions, masks and reset values
// ---------------------------------------------------------------
`define SCA_DC_STAGGER  6
`define SCA_DC_MERGE    4
`define SCA_DC_WDEN     3
`define SCA_DC_WDTO     1
`define SCA_DC_NOLATCH  0
`define SCA_AC_VOUT     4
`define SCA_AC_TEMP     3
`define SCA_AC_LOAD_CURRENT_SENSING     2
`define SCA_AC_VBB      1
`define SCA_VR_FRESH    10
`define SCA_FT_WDERR    7
`define SCA_DEVCFG_WMASK 16'h005F
`define SCA_ADCCFG_WMASK 16'h001E
`define SCA_DEVCFG_RST  16'h0000
`define SCA_ADCCFG_RST  16'h001A
`define SCA_VBBRES_RST  16'h0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SCA_CLK_MHZ     40
`define SCA_STAGGER_US  100
`define SCA_STAGGER_CYC (`SCA_STAGGER_US * `SCA_CLK_MHZ)
`define SCA_WD0_US      400
`define SCA_WD1_MS      400
`define SCA_WD2_MS      800
`define SCA_WD3_MS      1200
`define SCA_WD0_CYC     (`SCA_WD0_US * `SCA_CLK_MHZ)
`define SCA_WD1_CYC     (`SCA_WD1_MS * 1000 * `SCA_CLK_MHZ)
`define SCA_WD2_CYC     (`SCA_WD2_MS * 1000 * `SCA_CLK_MHZ)
`define SCA_WD3_CYC     (`SCA_WD3_MS * 1000 * `SCA_CLK_MHZ)

`endif

// >>> core/sca_pkg.sv
// Purpose: Types for the switch configuration and ADC register slice
// Assumes: Constants come from sca_defines.svh
// Notes:   Types only
package sca_pkg;

   typedef enum logic [1:0] {
      SCA_WD_400US  = 2'b00,
      SCA_WD_400MS  = 2'b01,
      SCA_WD_800MS  = 2'b10,
      SCA_WD_1200MS = 2'b11
   } sca_wd_sel_type;

   typedef enum logic {
      SCA_STG_IDLE = 1'b0,
      SCA_STG_WAIT = 1'b1
   } sca_stg_state_type;

endpackage : sca_pkg

// >>> core/sca_regs.sv
// Purpose: Device config, ADC sequence config and supply result registers
// Assumes: Frame port is driven by the SPI shell on this clock
// Notes:   Fault register and pin fold in the watchdog error
`timescale 1ns/1ps
`include "sca_defines.svh"
module sca_regs #(
   parameter int          NF      = 7,
   parameter logic [25:0] WD0_CYC = 26'(`SCA_WD0_CYC),
   parameter logic [25:0] WD1_CYC = 26'(`SCA_WD1_CYC),
   parameter logic [25:0] WD2_CYC = 26'(`SCA_WD2_CYC),
   parameter logic [25:0] WD3_CYC = 26'(`SCA_WD3_CYC)
) (
   input  wire logic          clk,               // core clock
   input  wire logic          rst_n,             // sync reset
   input  wire logic          frame_valid,       // valid frame pulse
   input  wire logic          frame_wr,          // 1 write, 0 read
   input  wire logic [5:0]    frame_addr,        // register index
   input  wire logic [15:0]   frame_wdata,       // write data
   input  wire logic          frame_ch_en_set,   // frame turns a channel on
   input  wire logic [1:0]    ch_enable,         // channel enable bits
   input  wire logic          adc_enable,        // converter enable
   input  wire logic          watchdog_error_mask, // hide watchdog error from fault register and pin
   input  wire logic [NF-1:0] fault_cond,        // live fault conditions
   input  wire logic          adc_vbb_done,      // supply sample pulse
   input  wire logic [9:0]    adc_vbb_data,      // supply sample
   input  wire logic          pwm_first_edge,    // first PWM edge request
   output logic [15:0]        rdata,             // read data
   output logic               rdata_valid,       // read data pulse
   output logic               ch1_pwm_start,     // channel 1 edge pulse
   output logic               ch2_pwm_start,     // channel 2 edge pulse
   output logic               channels_parallel, // channels merged
   output logic [3:0]         conv_select,       // vout,temp,load_current_sensing,vbb
   output logic               fault_pin_out,     // any fault, high
   output logic               watchdog_error     // timeout pulse
);
   import sca_pkg::*;

   localparam logic [11:0] STG_LOAD = 12'(`SCA_STAGGER_CYC - 1);

   logic [15:0]       devcfg_reg;
   logic [15:0]       adccfg_reg;
   logic [9:0]        vbb_reg;
   logic              fresh_reg;
   logic [NF:0]       fault_reg;
   logic [NF:0]       fault_next;
   logic [NF:0]       fault_raw;
   logic [11:0]       stg_cnt_reg;
   sca_stg_state_type stg_state_reg;
   logic              spi_watchdog_timeout_select;
   logic              wr_hit;
   logic              rd_hit;
   logic              vbb_take;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
      hit = (a == o);
   endfunction : hit

   assign wr_hit   = frame_valid && frame_wr;
   assign rd_hit   = frame_valid && !frame_wr;
   assign vbb_take = adc_vbb_done && conv_select[0];

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         devcfg_reg <= `SCA_DEVCFG_RST;
      end else if (wr_hit && hit(frame_addr, `SCA_OFS_DEVCFG)) begin
         devcfg_reg <= frame_wdata & `SCA_DEVCFG_WMASK;
         // Merge only safe with both FETs off
         if (ch_enable != 2'b00 || frame_ch_en_set) begin
            devcfg_reg[`SCA_DC_MERGE] <= devcfg_reg[`SCA_DC_MERGE];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         adccfg_reg <= `SCA_ADCCFG_RST;
      end else if (wr_hit && hit(frame_addr, `SCA_OFS_ADCCFG)) begin
         adccfg_reg <= frame_wdata & `SCA_ADCCFG_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         channels_parallel <= 1'b0;
         conv_select       <= 4'h0;
      end else begin
         channels_parallel <= devcfg_reg[`SCA_DC_MERGE];
         conv_select <= {4{adc_enable}} & ~{
            adccfg_reg[`SCA_AC_VOUT],
            adccfg_reg[`SCA_AC_TEMP],
            adccfg_reg[`SCA_AC_LOAD_CURRENT_SENSING],
            adccfg_reg[`SCA_AC_VBB]};
      end
   end

   // ---------------------------------------------------------------
   // Supply result and fresh flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         vbb_reg   <= 10'h000;
         fresh_reg <= 1'b0;
      end else begin
         if (vbb_take) begin
            vbb_reg <= adc_vbb_data;
         end
         // New sample beats a read in the same cycle
         if (vbb_take) begin
            fresh_reg <= 1'b1;
         end else if (rd_hit && hit(frame_addr, `SCA_OFS_VBBRES)) begin
            fresh_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Watchdog and fault register
   // ---------------------------------------------------------------
   sca_wd_timer #(
      .WD0_CYC (WD0_CYC),
      .WD1_CYC (WD1_CYC),
      .WD2_CYC (WD2_CYC),
      .WD3_CYC (WD3_CYC)
   ) u_wd (
      .clk     (clk),
      .rst_n   (rst_n),
      .enable  (devcfg_reg[`SCA_DC_WDEN]),
      .sel     (sca_wd_sel_type'(devcfg_reg[`SCA_DC_WDTO +: 2])),
      .kick    (frame_valid),
      .timeout (spi_watchdog_timeout_select)
   );

   assign fault_raw = {spi_watchdog_timeout_select && !watchdog_error_mask, fault_cond};

   always_comb begin
      if (devcfg_reg[`SCA_DC_NOLATCH]) begin
         fault_next = fault_raw;
      end else if (rd_hit && hit(frame_addr, `SCA_OFS_FAULT)) begin
         fault_next = fault_raw;
      end else begin
         fault_next = fault_reg | fault_raw;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_reg      <= '0;
         fault_pin_out  <= 1'b0;
         watchdog_error <= 1'b0;
      end else begin
         fault_reg      <= fault_next;
         fault_pin_out  <= |fault_next;
         watchdog_error <= spi_watchdog_timeout_select;
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata       <= 16'h0000;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= rd_hit;
         rdata       <= 16'h0000;
         if (rd_hit) begin
            case (frame_addr)
               `SCA_OFS_DEVCFG: rdata <= devcfg_reg;
               `SCA_OFS_ADCCFG: rdata <= adccfg_reg;
               `SCA_OFS_VBBRES: rdata <= {5'h00, fresh_reg, vbb_reg};
               `SCA_OFS_FAULT:  rdata <= 16'(fault_reg);
               default:         rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // PWM first-edge stagger
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stg_state_reg <= SCA_STG_IDLE;
         stg_cnt_reg   <= 12'h000;
         ch1_pwm_start <= 1'b0;
         ch2_pwm_start <= 1'b0;
      end else begin
         ch1_pwm_start <= pwm_first_edge;
         ch2_pwm_start <= 1'b0;
         case (stg_state_reg)
            SCA_STG_IDLE: begin
               if (pwm_first_edge && devcfg_reg[`SCA_DC_STAGGER]) begin
                  ch2_pwm_start <= 1'b1;
               end else if (pwm_first_edge) begin
                  stg_cnt_reg   <= STG_LOAD;
                  stg_state_reg <= SCA_STG_WAIT;
               end
            end
            SCA_STG_WAIT: begin
               if (stg_cnt_reg == 12'h000) begin
                  ch2_pwm_start <= 1'b1;
                  stg_state_reg <= SCA_STG_IDLE;
               end else begin
                  stg_cnt_reg <= stg_cnt_reg - 12'h001;
               end
            end
            default: stg_state_reg <= SCA_STG_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   stagger_align_a : assert property (
      ch1_pwm_start && $past(devcfg_reg[`SCA_DC_STAGGER])
         && stg_state_reg == SCA_STG_IDLE |-> ch2_pwm_start)
      else $error("aligned edges not together");
   stagger_wait_a : assert property (
      $rose(stg_state_reg == SCA_STG_WAIT) |-> stg_cnt_reg == STG_LOAD
         && !ch2_pwm_start)
      else $error("stagger delay not loaded");
   merge_guard_a : assert property (
      wr_hit && hit(frame_addr, `SCA_OFS_DEVCFG) && ch_enable != 2'b00
      |=> $stable(devcfg_reg[`SCA_DC_MERGE]))
      else $error("merge bit written with channel on");
   merge_out_a : assert property (
      devcfg_reg[`SCA_DC_MERGE] |=> channels_parallel)
      else $error("parallel indication missing");
   fault_hold_a : assert property (
      !devcfg_reg[`SCA_DC_NOLATCH] && fault_reg[0]
      && !(rd_hit && hit(frame_addr, `SCA_OFS_FAULT)) |=> fault_reg[0])
      else $error("latched fault lost without read");
   fault_follow_a : assert property (
      devcfg_reg[`SCA_DC_NOLATCH] && !fault_cond[0] |=> !fault_reg[0])
      else $error("unlatched fault held");
   conv_skip_a : assert property (
      (adccfg_reg[4:1] & conv_select) == 4'h0 || $changed(adccfg_reg))
      else $error("disabled conversion selected");
   fresh_set_a : assert property (
      vbb_take |=> fresh_reg && vbb_reg == $past(adc_vbb_data))
      else $error("fresh flag or sample not taken");
   result_fmt_a : assert property (
      rdata_valid && $past(frame_addr) == `SCA_OFS_VBBRES
      |-> rdata[15:11] == 5'h00)
      else $error("supply result upper bits set");
   adc_off_a : assert property (
      !adc_enable |=> conv_select == 4'h0)
      else $error("conversion selected while ADC off");
   wd_mask_a : assert property (
      spi_watchdog_timeout_select && watchdog_error_mask && !fault_reg[`SCA_FT_WDERR]
      |=> !fault_reg[`SCA_FT_WDERR])
      else $error("masked watchdog error reported");
   fresh_clr_a : assert property (
      rd_hit && hit(frame_addr, `SCA_OFS_VBBRES) && !vbb_take |=> !fresh_reg)
      else $error("fresh flag not cleared by read");

   stagger_c : cover property (ch2_pwm_start && !ch1_pwm_start);
   fault_pin_c : cover property ($rose(fault_pin_out));
   fresh_c : cover property (fresh_reg ##1 !fresh_reg);

endmodule : sca_regs

// >>> core/sca_wd_timer.sv
// Purpose: SPI watchdog window counter
// Assumes: kick is a one-cycle pulse per valid frame
// Notes:   timeout is a one-cycle pulse, then the window restarts
`timescale 1ns/1ps
`include "sca_defines.svh"
module sca_wd_timer #(
   parameter logic [25:0] WD0_CYC = 26'(`SCA_WD0_CYC),
   parameter logic [25:0] WD1_CYC = 26'(`SCA_WD1_CYC),
   parameter logic [25:0] WD2_CYC = 26'(`SCA_WD2_CYC),
   parameter logic [25:0] WD3_CYC = 26'(`SCA_WD3_CYC)
) (
   input  wire logic                    clk,     // core clock
   input  wire logic                    rst_n,   // sync reset
   input  wire logic                    enable,  // watchdog on
   input  wire sca_pkg::sca_wd_sel_type sel,     // window select
   input  wire logic                    kick,    // valid frame seen
   output logic                         timeout  // window expired
);
   import sca_pkg::*;

   logic [25:0] cnt_reg;
   logic [25:0] limit;

   // ---------------------------------------------------------------
   // Window select
   // ---------------------------------------------------------------
   always_comb begin
      case (sel)
         SCA_WD_400US:  limit = WD0_CYC;
         SCA_WD_400MS:  limit = WD1_CYC;
         SCA_WD_800MS:  limit = WD2_CYC;
         SCA_WD_1200MS: limit = WD3_CYC;
         default:       limit = WD0_CYC;
      endcase
   end

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || !enable || kick) begin
         cnt_reg <= 26'h0000000;
         timeout <= 1'b0;
      end else if (cnt_reg >= limit - 26'h0000001) begin
         cnt_reg <= 26'h0000000;
         timeout <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 26'h0000001;
         timeout <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   wd_needs_enable_a : assert property (
      @(posedge clk) disable iff (!rst_n)
      timeout |-> $past(enable) && !$past(kick))
      else $error("watchdog fired while disabled or kicked");
   wd_window_a : assert property (
      @(posedge clk) disable iff (!rst_n)
      timeout |-> $past(cnt_reg) == $past(limit) - 26'h0000001)
      else $error("watchdog fired at wrong count");
   wd_fire_c : cover property (@(posedge clk) disable iff (!rst_n) timeout);

endmodule : sca_wd_timer

// >>> tb/sca_host_model.sv
// Purpose: Host controller model that issues decoded SPI frames
// Assumes: Frames launch just after a rising edge of clk
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ps
module sca_host_model (
   input  wire logic        clk,            // core clock
   input  wire logic [15:0] rdata,          // read data
   input  wire logic        rdata_valid,    // read data pulse
   output logic             frame_valid,    // frame pulse
   output logic             frame_wr,       // 1 write, 0 read
   output logic [5:0]       frame_addr,     // register index
   output logic [15:0]      frame_wdata,    // write data
   output logic             frame_ch_en_set // frame turns a channel on
);
   initial begin
      frame_valid = 1'b0;
      frame_wr = 1'b0;
      frame_addr = 6'h00;
      frame_wdata = 16'h0000;
      frame_ch_en_set = 1'b0;
   end

   // Each frame is a valid command, so it restarts the watchdog window
   task automatic xfer(input logic wr, input logic [5:0] a,
                       input logic [15:0] d, input logic chs,
                       output logic [15:0] q);
      @(posedge clk);
      frame_valid <= 1'b1;
      frame_wr <= wr;
      frame_addr <= a;
      frame_wdata <= d;
      frame_ch_en_set <= chs;
      @(posedge clk);
      frame_valid <= 1'b0;
      frame_addr <= ~a;
      frame_wdata <= ~d;
      frame_ch_en_set <= 1'b0;
      #1;
      // Answer stands one cycle only: take it now or lose it
      q = rdata_valid ? rdata : 16'hXXXX;
   endtask : xfer
endmodule : sca_host_model

// >>> tb/sca_regs_tb.sv
// Purpose: Self-checking bench for the config and ADC register slice
// Assumes: Watchdog windows shortened to 20, 40, 60 and 80 cycles
// Notes:   Register model kept in plain variables beside the design
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((e) !== (a)) begin \
miscompares++; $display("FAIL %s exp %0h got %0h", nm, e, a); end end
module sca_regs_tb;
   import sca_pkg::*;
   logic        clk, rst_n, frame_valid, frame_wr, frame_ch_en_set;
   logic [5:0]  frame_addr;
   logic [15:0] frame_wdata, rdata, dev, adc, vres;
   logic [1:0]  ch_enable;
   logic [6:0]  fault_cond;
   logic [9:0]  adc_vbb_data;
   logic [3:0]  conv_select;
   logic        adc_enable, watchdog_error_mask, adc_vbb_done;
   logic        pwm_first_edge, rdata_valid, ch1_pwm_start;
   logic        ch2_pwm_start, channels_parallel, fault_pin_out;
   logic        watchdog_error;
   logic [31:0] r;
   int          miscompares, n_compared, n;
   int          wd[4] = '{20, 40, 60, 80};
   localparam int STG = 100 * 1000 / 25;

   sca_regs #(.WD0_CYC(26'h14), .WD1_CYC(26'h28), .WD2_CYC(26'h3C),
      .WD3_CYC(26'h50)) DUT (.clk, .rst_n, .frame_valid, .frame_wr,
      .frame_addr, .frame_wdata, .frame_ch_en_set, .ch_enable,
      .adc_enable, .watchdog_error_mask, .fault_cond, .adc_vbb_done,
      .adc_vbb_data, .pwm_first_edge, .rdata, .rdata_valid,
      .ch1_pwm_start, .ch2_pwm_start, .channels_parallel,
      .conv_select, .fault_pin_out, .watchdog_error);
   sca_host_model host (.clk, .rdata, .rdata_valid, .frame_valid,
      .frame_wr, .frame_addr, .frame_wdata, .frame_ch_en_set);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic chk_rd(input logic [5:0] a, input logic [15:0] e,
                         input string nm);
      logic [15:0] q;
      host.xfer(1'b0, a, 16'h0000, 1'b0, q);
      `CHK(nm, e, q)
   endtask : chk_rd

   // Merge bit keeps its old value when any channel is or turns on
   task automatic wr(input logic [5:0] a, input logic [15:0] d,
                     input logic chs = 1'b0);
      logic [15:0] q;
      logic        m;
      // Model after the frame edge, when the channel enables have settled
      host.xfer(1'b1, a, d, chs, q);
      m = (ch_enable != 2'b00 || chs) ? dev[4] : d[4];
      if (a == 6'h09) dev = {d[15:5] & 11'h002, m, d[3:0]};
      if (a == 6'h0A) adc = d & 16'h001E;
   endtask : wr

   initial begin
      #(60000 * 25);
      miscompares++;
      summarize();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      ch_enable = 2'b00;
      adc_enable = 1'b0;
      watchdog_error_mask = 1'b0;
      fault_cond = 7'h00;
      adc_vbb_done = 1'b0;
      adc_vbb_data = 10'h000;
      pwm_first_edge = 1'b0;
      dev = 16'h0000;
      adc = 16'h001A;
      vres = 16'h0000;
      r = $urandom(38966);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      chk_rd(6'h09, dev, "devcfg reset");
      chk_rd(6'h0A, adc, "adccfg reset");
      chk_rd(6'h0B, vres, "result reset");
      chk_rd(6'h3F, 16'h0000, "unmapped");
      @(posedge clk) ch_enable <= 2'b01;
      wr(6'h09, 16'h0010);
      chk_rd(6'h09, dev, "merge busy");
      @(posedge clk) ch_enable <= 2'b00;
      wr(6'h09, 16'h0010, 1'b1);
      chk_rd(6'h09, dev, "merge same frame");
      wr(6'h09, 16'h0010);
      chk_rd(6'h09, dev, "merge free");
      `CHK("parallel", 1'b1, channels_parallel)
      @(posedge clk) ch_enable <= 2'b10;
      wr(6'h09, 16'hFFE7);
      chk_rd(6'h09, dev, "devcfg fields");
      @(posedge clk) ch_enable <= 2'b00;
      wr(6'h09, 16'h0000);
      @(posedge clk);
      #1;
      `CHK("parallel", dev[4], channels_parallel)
      for (int i = 0; i < 9; i++) begin
         r = (i == 8) ? 32'h20 : $urandom;
         @(posedge clk) adc_enable <= r[5];
         wr(6'h0A, r[15:0]);
         chk_rd(6'h0A, adc, "adccfg");
         `CHK("conv sel", {4{r[5]}} & ~adc[4:1], conv_select)
      end
      for (int i = 0; i < 2; i++) begin
         r = $urandom;
         @(posedge clk);
         adc_vbb_done <= 1'b1;
         adc_vbb_data <= r[9:0];
         @(posedge clk);
         adc_vbb_done <= 1'b0;
         if (adc[1] == 1'b0) vres = {6'h01, r[9:0]};
         chk_rd(6'h0B, vres, "fresh sample");
         vres[10] = 1'b0;
         chk_rd(6'h0B, vres, "read clears");
         wr(6'h0A, 16'h0002);
      end
      for (int s = 0; s < 2; s++) begin
         wr(6'h09, {9'h000, s[0], 6'h00});
         @(posedge clk) pwm_first_edge <= 1'b1;
         @(posedge clk) pwm_first_edge <= 1'b0;
         #1;
         `CHK("first edge", 1'b1, ch1_pwm_start)
         n = 0;
         while (ch2_pwm_start !== 1'b1 && n < STG + 50) begin
            @(posedge clk);
            #1;
            n++;
         end
         `CHK("stagger", (s == 0) ? STG : 0, n)
      end
      for (int k = 0; k < 5; k++) begin
         @(posedge clk) watchdog_error_mask <= (k == 4);
         wr(6'h09, {12'h000, 1'b1, k[1:0], 1'b0});
         n = 0;
         while (watchdog_error !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
         end
         `CHK("wd window", 1'b1, n >= wd[k%4] - 1 && n <= wd[k%4] + 2)
         @(posedge clk);
         #1;
         `CHK("wd pin", k != 4, fault_pin_out)
         chk_rd(6'h02, {8'h00, k != 4, 7'h00}, "wd fault");
      end
      for (int l = 0; l < 2; l++) begin
         wr(6'h09, {15'h0000, l[0]});
         r = $urandom | 32'h1;
         @(posedge clk) fault_cond <= r[6:0];
         repeat (2) @(posedge clk);
         #1;
         `CHK("fault pin", 1'b1, fault_pin_out)
         @(posedge clk) fault_cond <= 7'h00;
         repeat (3) @(posedge clk);
         chk_rd(6'h02, l ? 16'h0000 : {9'h000, r[6:0]}, "held");
         chk_rd(6'h02, 16'h0000, "cleared");
      end
      summarize();
   end
endmodule : sca_regs_tb
